// ### core/pxf_map.svh
`ifndef PXF_MAP_SVH
`define PXF_MAP_SVH

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define PXF_OFS_CTRL        8'h00
`define PXF_OFS_PHY1        8'h04
`define PXF_OFS_PORT        8'h08
`define PXF_OFS_CONN        8'h0C
`define PXF_OFS_STAT        8'h10
`define PXF_OFS_PING        8'h14

// ---------------------------------------------
// Control register fields
// ---------------------------------------------
`define PXF_CTRL_AUTO       0
`define PXF_CTRL_RCV        1
`define PXF_CTRL_LINK       2
`define PXF_CTRL_ACCEL      3
`define PXF_CTRL_MULTI      4
`define PXF_CTRL_SRST       5
`define PXF_CTRL_LRST       6
`define PXF_CTRL_RESUME     7
`define PXF_CTRL_RESET      8'h07

// ---------------------------------------------
// PHY registers 0001b and 0101b and port register fields
// ---------------------------------------------
`define PXF_PHY1_ADDR       4'h1
`define PXF_PHY5_ADDR       4'h5
`define PXF_PHY1_RHB        7
`define PXF_GAP_RESET       6'h3F
`define PXF_PAGE_PORT       3'h0
`define PXF_PORT_DIS        8
`define PXF_LOCAL_PORT      4'h0

// ---------------------------------------------
// Status register fields
// ---------------------------------------------
`define PXF_STAT_CONN       0
`define PXF_STAT_RST        1
`define PXF_STAT_CFGERR     2
`define PXF_STAT_SPDWARN    3
`define PXF_STAT_PME        4

// ---------------------------------------------
// Remote command codes
// ---------------------------------------------
`define PXF_CMD_DISABLE     3'h1
`define PXF_CMD_ENABLE      3'h5

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define PXF_CLK_NS          100
`define PXF_SHORT_RST_NS    1300
`define PXF_LONG_RST_NS     167000
`define PXF_MIN_IDLE_NS     400
`define PXF_ARB_GAP_NS      1000
`define PXF_SHORT_RST_CYC   ((`PXF_SHORT_RST_NS + `PXF_CLK_NS - 1) / `PXF_CLK_NS)
`define PXF_LONG_RST_CYC    ((`PXF_LONG_RST_NS + `PXF_CLK_NS - 1) / `PXF_CLK_NS)
`define PXF_MIN_IDLE_CYC    ((`PXF_MIN_IDLE_NS + `PXF_CLK_NS - 1) / `PXF_CLK_NS)
`define PXF_ARB_GAP_CYC     ((`PXF_ARB_GAP_NS + `PXF_CLK_NS - 1) / `PXF_CLK_NS)
`define PXF_CONN_TO_RESET   16'h0100
`define PXF_RST_DET_RESET   16'h0010

`endif

// ### core/pxf_pkg.sv
package pxf_pkg;

    // ---------------------------------------------
    // Remote command sequencer states
    // ---------------------------------------------
    typedef enum logic [3:0] {
        PXF_RC_IDLE    = 4'h1,
        PXF_RC_NOTIFY  = 4'h2,
        PXF_RC_EXEC    = 4'h4,
        PXF_RC_CONFIRM = 4'h8
    } pxf_rcmd_state_t;

endpackage

// ### core/pxf_sync.sv
`timescale 1ns/1ps

module pxf_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // Two stages per bit; first stage read only by the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                meta[i] <= 1'b0;
                q[i]    <= 1'b0;
            end else begin
                meta[i] <= d[i];
                q[i]    <= meta[i];
            end
        end
    end

endmodule

// ### core/pxf_conn.sv
`timescale 1ns/1ps

module pxf_conn (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        port_conn,
    input  wire logic        bus_reset_in,
    input  wire logic [15:0] conn_timeout,
    input  wire logic [15:0] reset_detect,
    output logic             connected,
    output logic             timer_running,
    output logic             conn_event
);

    logic [15:0] conn_cnt;
    logic [15:0] rst_cnt;
    wire         conn_done = (conn_cnt > conn_timeout);
    wire         rst_done  = bus_reset_in && (rst_cnt > reset_detect);

    assign timer_running = port_conn && !connected;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conn_cnt   <= 16'h0000;
            rst_cnt    <= 16'h0000;
            connected  <= 1'b0;
            conn_event <= 1'b0;
        end else begin
            conn_event <= 1'b0;
            rst_cnt    <= bus_reset_in ? rst_cnt + 16'h0001 : 16'h0000;
            if (!port_conn) begin
                conn_cnt  <= 16'h0000;
                connected <= 1'b0;
            end else if (!connected) begin
                conn_cnt <= conn_cnt + 16'h0001;
                if (conn_done || rst_done) begin
                    connected  <= 1'b1;
                    conn_event <= 1'b1;
                end
            end
        end
    end

endmodule

// ### core/pxf_top.sv
`timescale 1ns/1ps
`include "pxf_map.svh"

module pxf_top (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [5:0]  NODE_ID,
    input  wire logic        PCFG_VALID,
    input  wire logic [5:0]  PCFG_ROOT_NODE_FIELD,
    input  wire logic        PCFG_R,
    input  wire logic        PCFG_T,
    input  wire logic [5:0]  PCFG_GAP,
    output logic             RXF_PUSH,
    output logic      [31:0] RXF_DATA,
    input  wire logic        PORT_CONNECT,
    input  wire logic        PORT_IS_CHILD,
    input  wire logic        BUS_RESET_IN,
    input  wire logic        BUS_IDLE,
    input  wire logic        SYS_POWER_OFF,
    input  wire logic        RX_ACTIVE,
    input  wire logic        TX_PENDING,
    input  wire logic        CHILD_REPEAT_END,
    output logic             ARB_START,
    output logic             FLYBY_TX,
    output logic             BUS_RESET_OUT,
    input  wire logic        TX_PKT_START,
    input  wire logic        TX_CONCAT,
    input  wire logic [1:0]  TX_SPEED,
    output logic             SPD_SIG,
    output logic      [1:0]  SPD_CODE,
    input  wire logic        PING_RX,
    output logic             SELFID_TX,
    input  wire logic        PING_TX_DONE,
    input  wire logic        ASYNC_TX_DONE,
    input  wire logic        SELFID_RX,
    input  wire logic        ACK_RX,
    input  wire logic        PING_FLAG,
    output logic             TSTAMP_WR,
    output logic      [15:0] TSTAMP_VAL,
    input  wire logic        PKT_RX,
    output logic             ACK_TARDY,
    output logic             PME_B,
    input  wire logic        RCMD_VALID,
    input  wire logic [2:0]  RCMD_CODE,
    input  wire logic [3:0]  RCMD_PORT,
    output logic             DIS_NOTIFY_TX,
    output logic             RCONF_TX,
    input  wire logic        RACC_VALID,
    input  wire logic [3:0]  RACC_ADDR,
    output logic             RREPLY_TX,
    output logic      [7:0]  RREPLY_DATA,
    input  wire logic        RESUME_RX,
    output logic             RESUME_TX,
    output logic             RESUME_START,
    output logic             PORT_BIAS_EN
);

    // ---------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------
    logic [4:0] pin_s;

    pxf_sync #(.W(5)) u_sync (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .d     ({SYS_POWER_OFF, BUS_IDLE, BUS_RESET_IN, PORT_IS_CHILD, PORT_CONNECT}),
        .q     (pin_s)
    );

    wire conn_s  = pin_s[0];
    wire child_s = pin_s[1];
    wire brst_s  = pin_s[2];
    wire idle_s  = pin_s[3];
    wire poff_s  = pin_s[4];

    // ---------------------------------------------
    // Registers
    // ---------------------------------------------
    logic [7:0]  ctrl;
    logic        root_holdoff_bit;
    logic [5:0]  gap;
    logic [2:0]  page_sel;
    logic [3:0]  port_sel;
    logic        port_dis;
    logic [15:0] conn_to;
    logic [15:0] rst_det;
    logic        spd_warn;
    logic        pme_pend;
    logic [15:0] ping_cnt;
    logic        ping_run;
    logic        conn_s_d;
    logic        brst_s_d;
    logic [1:0]  last_spd;
    logic [15:0] idle_cnt;
    logic [15:0] rst_cnt;
    logic        srst_pend;
    pxf_pkg::pxf_rcmd_state_t rc_state;
    pxf_pkg::pxf_rcmd_state_t next_rc_state;
    logic [2:0]  rc_code;
    logic [3:0]  rc_port;
    logic        conn_ok;
    logic        conn_timing;
    logic        conn_evt;

    wire auto_phy_packet_handling  = ctrl[`PXF_CTRL_AUTO];
    wire phy_packet_receive_enable = ctrl[`PXF_CTRL_RCV];
    wire link_enable_bit           = ctrl[`PXF_CTRL_LINK];
    wire enab_accel                = ctrl[`PXF_CTRL_ACCEL];
    wire enab_multi                = ctrl[`PXF_CTRL_MULTI];

    // ---------------------------------------------
    // APB decode
    // ---------------------------------------------
    wire apb_acc   = PSEL && PENABLE && !PREADY;
    wire apb_done  = PSEL && PENABLE && PREADY;
    wire wr_en     = apb_done && PWRITE;
    wire hit_ctrl  = (PADDR == `PXF_OFS_CTRL);
    wire hit_phy1  = (PADDR == `PXF_OFS_PHY1);
    wire hit_port  = (PADDR == `PXF_OFS_PORT);
    wire hit_conn  = (PADDR == `PXF_OFS_CONN);
    wire hit_stat  = (PADDR == `PXF_OFS_STAT);
    wire hit_ping  = (PADDR == `PXF_OFS_PING);
    wire mapped    = hit_ctrl | hit_phy1 | hit_port | hit_conn | hit_stat | hit_ping;
    wire cfg_err   = !auto_phy_packet_handling && !phy_packet_receive_enable;
    wire rst_act   = (rst_cnt != 16'h0000);

    wire [31:0] stat_word = {27'h0000000, pme_pend, spd_warn, cfg_err, rst_act, conn_ok};
    wire [31:0] rd_word   = hit_ctrl ? {24'h000000, ctrl} :
                            hit_phy1 ? {24'h000000, root_holdoff_bit, 1'b0, gap} :
                            hit_port ? {23'h000000, port_dis, 1'b0, page_sel, port_sel} :
                            hit_conn ? {rst_det, conn_to} :
                            hit_stat ? stat_word :
                            hit_ping ? {16'h0000, ping_cnt} : 32'h00000000;

    // PHY register image for remote reads
    function automatic logic [7:0] phy_reg(input logic [3:0] a);
        case (a)
            `PXF_PHY1_ADDR: phy_reg = {root_holdoff_bit, srst_pend, gap};
            `PXF_PHY5_ADDR: phy_reg = {6'h00, enab_accel, enab_multi};
            default:        phy_reg = 8'h00;
        endcase
    endfunction

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= apb_acc;
            PSLVERR <= apb_acc && !mapped;
            PRDATA  <= (apb_acc && !PWRITE) ? rd_word : 32'h00000000;
        end
    end

    // ---------------------------------------------
    // Control and port registers
    // ---------------------------------------------
    wire srst_set = wr_en && hit_ctrl && PWDATA[`PXF_CTRL_SRST];
    wire lrst_set = wr_en && hit_ctrl && PWDATA[`PXF_CTRL_LRST];
    wire res_set  = wr_en && hit_ctrl && PWDATA[`PXF_CTRL_RESUME];

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ctrl <= `PXF_CTRL_RESET;
        end else if (wr_en && hit_ctrl) begin
            // Request bits are strobes, never stored
            ctrl <= {3'h0, PWDATA[4:0]};
        end
    end

    wire rc_dis  = (rc_state == pxf_pkg::PXF_RC_EXEC) && (rc_code == `PXF_CMD_DISABLE)
                   && (rc_port == `PXF_LOCAL_PORT);
    wire rc_en   = (rc_state == pxf_pkg::PXF_RC_EXEC) && (rc_code == `PXF_CMD_ENABLE)
                   && (rc_port == `PXF_LOCAL_PORT);
    wire sw_port = wr_en && hit_port && (PWDATA[6:4] == `PXF_PAGE_PORT)
                   && (PWDATA[3:0] == `PXF_LOCAL_PORT);

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            page_sel <= 3'h0;
            port_sel <= 4'h0;
            port_dis <= 1'b0;
            conn_to  <= `PXF_CONN_TO_RESET;
            rst_det  <= `PXF_RST_DET_RESET;
        end else begin
            if (wr_en && hit_port) begin
                page_sel <= PWDATA[6:4];
                port_sel <= PWDATA[3:0];
            end
            if (wr_en && hit_conn) begin
                conn_to <= PWDATA[15:0];
                rst_det <= PWDATA[31:16];
            end
            if (rc_dis) begin
                port_dis <= 1'b1;
            end else if (rc_en) begin
                port_dis <= 1'b0;
            end else if (sw_port) begin
                port_dis <= PWDATA[`PXF_PORT_DIS];
            end
        end
    end

    // ---------------------------------------------
    // PHY configuration packet handling
    // ---------------------------------------------
    // manual mode delivers to FIFO; blocks it while link off
    wire to_fifo  = PCFG_VALID && link_enable_bit && !auto_phy_packet_handling
                    && phy_packet_receive_enable;
    // automatic update; also while link off
    wire auto_upd = PCFG_VALID && (!link_enable_bit
                    || (auto_phy_packet_handling && !phy_packet_receive_enable));

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            root_holdoff_bit      <= 1'b0;
            gap      <= `PXF_GAP_RESET;
            RXF_PUSH <= 1'b0;
            RXF_DATA <= 32'h00000000;
        end else begin
            RXF_PUSH <= to_fifo;
            if (to_fifo) begin
                RXF_DATA <= {2'h0, PCFG_ROOT_NODE_FIELD, PCFG_R, PCFG_T, PCFG_GAP, 16'h0000};
            end
            if (auto_upd) begin
                root_holdoff_bit <= PCFG_R && (PCFG_ROOT_NODE_FIELD == NODE_ID);
                if (PCFG_T) begin
                    gap <= PCFG_GAP;
                end
            end else if (wr_en && hit_phy1) begin
                root_holdoff_bit <= PWDATA[`PXF_PHY1_RHB];
                gap <= PWDATA[5:0];
            end
        end
    end

    // ---------------------------------------------
    // Connection hysteresis and bus reset
    // ---------------------------------------------
    // connection debounce
    pxf_conn u_conn (
        .clk           (CLK_SYS),
        .rst_b         (RST_B),
        .port_conn     (conn_s),
        .bus_reset_in  (brst_s),
        .conn_timeout  (conn_to),
        .reset_detect  (rst_det),
        .connected     (conn_ok),
        .timer_running (conn_timing),
        .conn_event    (conn_evt)
    );

    wire brst_rise = brst_s && !brst_s_d;
    wire auto_srst = conn_evt || (conn_s_d && !conn_s && child_s)
                     || (brst_rise && RX_ACTIVE) || (brst_rise && conn_timing);
    wire arb_point = idle_s && (idle_cnt == (enab_accel ? 16'(`PXF_MIN_IDLE_CYC) : 16'(`PXF_ARB_GAP_CYC)));

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            conn_s_d  <= 1'b0;
            brst_s_d  <= 1'b0;
            srst_pend <= 1'b0;
            rst_cnt   <= 16'h0000;
            idle_cnt  <= 16'h0000;
            BUS_RESET_OUT <= 1'b0;
            ARB_START <= 1'b0;
            FLYBY_TX  <= 1'b0;
        end else begin
            conn_s_d <= conn_s;
            brst_s_d <= brst_s;
            // arbitration after idle gap, shorter when accelerated
            idle_cnt  <= idle_s ? idle_cnt + 16'h0001 : 16'h0000;
            ARB_START <= arb_point && (TX_PENDING || srst_pend) && !rst_act;
            // fly-by append on child repeat end
            FLYBY_TX  <= CHILD_REPEAT_END && TX_PENDING && !rst_act;
            if (lrst_set) begin
                rst_cnt <= 16'(`PXF_LONG_RST_CYC);
            end else if (srst_pend && arb_point && !rst_act) begin
                rst_cnt <= 16'(`PXF_SHORT_RST_CYC);
            end else if (rst_act) begin
                rst_cnt <= rst_cnt - 16'h0001;
            end
            if (srst_set || auto_srst) begin
                srst_pend <= 1'b1;
            end else if (arb_point && !rst_act) begin
                srst_pend <= 1'b0;
            end
            BUS_RESET_OUT <= (rst_cnt > 16'h0001) || lrst_set || (srst_pend && arb_point && !rst_act);
        end
    end

    // ---------------------------------------------
    // Speed signaling, ping, timestamps
    // ---------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            SPD_SIG    <= 1'b0;
            SPD_CODE   <= 2'h0;
            last_spd   <= 2'h0;
            spd_warn   <= 1'b0;
            SELFID_TX  <= 1'b0;
            ping_run   <= 1'b0;
            ping_cnt   <= 16'h0000;
            TSTAMP_WR  <= 1'b0;
            TSTAMP_VAL <= 16'h0000;
        end else begin
            // per-packet speed signaling when multi enabled
            SPD_SIG <= TX_PKT_START && (enab_multi || !TX_CONCAT);
            if (TX_PKT_START) begin
                SPD_CODE <= TX_SPEED;
                last_spd <= TX_SPEED;
            end
            if (TX_PKT_START && TX_CONCAT && TX_SPEED == 2'h0 && last_spd != 2'h0) begin
                spd_warn <= 1'b1;
            end else if (wr_en && hit_stat && PWDATA[`PXF_STAT_SPDWARN]) begin
                spd_warn <= 1'b0;
            end
            SELFID_TX <= PING_RX;
            TSTAMP_WR <= 1'b0;
            if (PING_TX_DONE || ASYNC_TX_DONE) begin
                ping_run <= 1'b1;
                ping_cnt <= 16'h0000;
            end else if (ping_run && (SELFID_RX || ACK_RX)) begin
                ping_run   <= 1'b0;
                TSTAMP_WR  <= PING_FLAG;
                TSTAMP_VAL <= ping_cnt;
            end else if (ping_run) begin
                ping_cnt <= ping_cnt + 16'h0001;
            end
        end
    end

    // ---------------------------------------------
    // Power-off acknowledge
    // ---------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ACK_TARDY <= 1'b0;
            pme_pend  <= 1'b0;
            PME_B     <= 1'b1;
        end else begin
            // tardy ack first, PME one cycle later
            ACK_TARDY <= PKT_RX && poff_s;
            if (ACK_TARDY) begin
                pme_pend <= 1'b1;
            end else if (wr_en && hit_stat && PWDATA[`PXF_STAT_PME]) begin
                pme_pend <= 1'b0;
            end
            PME_B <= !(pme_pend || ACK_TARDY);
        end
    end

    // ---------------------------------------------
    // Remote packets and resume
    // ---------------------------------------------
    always_comb begin
        case (rc_state)
            pxf_pkg::PXF_RC_IDLE:    next_rc_state = RCMD_VALID ? pxf_pkg::PXF_RC_NOTIFY : pxf_pkg::PXF_RC_IDLE;
            pxf_pkg::PXF_RC_NOTIFY:  next_rc_state = pxf_pkg::PXF_RC_EXEC;
            pxf_pkg::PXF_RC_EXEC:    next_rc_state = pxf_pkg::PXF_RC_CONFIRM;
            pxf_pkg::PXF_RC_CONFIRM: next_rc_state = pxf_pkg::PXF_RC_IDLE;
            default:                 next_rc_state = pxf_pkg::PXF_RC_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rc_state      <= pxf_pkg::PXF_RC_IDLE;
            rc_code       <= 3'h0;
            rc_port       <= 4'h0;
            DIS_NOTIFY_TX <= 1'b0;
            RCONF_TX      <= 1'b0;
            RREPLY_TX     <= 1'b0;
            RREPLY_DATA   <= 8'h00;
            RESUME_TX     <= 1'b0;
            RESUME_START  <= 1'b0;
            PORT_BIAS_EN  <= 1'b1;
        end else begin
            rc_state <= next_rc_state;
            if (rc_state == pxf_pkg::PXF_RC_IDLE && RCMD_VALID) begin
                rc_code <= RCMD_CODE;
                rc_port <= RCMD_PORT;
            end
            DIS_NOTIFY_TX <= (rc_state == pxf_pkg::PXF_RC_NOTIFY) && (rc_code == `PXF_CMD_DISABLE);
            RCONF_TX <= (rc_state == pxf_pkg::PXF_RC_CONFIRM);
            RREPLY_TX <= RACC_VALID;
            if (RACC_VALID) begin
                RREPLY_DATA <= phy_reg(RACC_ADDR);
            end
            // resume on send or receive; disabled port stays unbiased
            RESUME_TX    <= res_set;
            RESUME_START <= (res_set || RESUME_RX) && !port_dis;
            PORT_BIAS_EN <= !port_dis;
        end
    end

endmodule

// ### verification/pxf_top_checker.sv
`timescale 1ns/1ps
module pxf_top_checker (
    input wire logic        CLK_SYS, RST_B, PCFG_VALID, RXF_PUSH, PING_RX, SELFID_TX, RACC_VALID,
    input wire logic        RREPLY_TX, ACK_TARDY, PME_B, PKT_RX, PING_FLAG, TSTAMP_WR, DIS_NOTIFY_TX, RCONF_TX,
    input wire logic [31:0] RXF_DATA
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Remote command pulses come in a fixed order
    sequence s_notify_conf;
        DIS_NOTIFY_TX ##2 RCONF_TX;
    endsequence
    chk_cfg_push: assert property (RXF_PUSH |-> $past(PCFG_VALID)) else $error("push without packet");
    chk_cfg_word: assert property (RXF_PUSH |-> RXF_DATA[31:30] == 2'h0 && RXF_DATA[15:0] == 16'h0)
        else $error("bad fifo word");
    chk_ping_reply: assert property (PING_RX |=> SELFID_TX) else $error("no self-ID");
    chk_tardy_pme: assert property (ACK_TARDY |=> !PME_B) else $error("no wake event");
    chk_tardy_cause: assert property (ACK_TARDY |-> $past(PKT_RX)) else $error("stray tardy ack");
    chk_access_reply: assert property (RACC_VALID |=> RREPLY_TX) else $error("no reply");
    chk_stamp_flag: assert property (TSTAMP_WR |-> $past(PING_FLAG)) else $error("stamp without flag");
    chk_confirm_after: assert property (DIS_NOTIFY_TX |-> s_notify_conf) else $error("no confirm");
endmodule
bind pxf_top pxf_top_checker u_pxf_top_checker (.*);

// ### verification/pxf_peer.sv
`timescale 1ns/1ps
module pxf_peer (
    input  wire logic       clk,
    input  wire logic       ping_sent,
    input  wire logic [7:0] dly,
    output logic            selfid
);
    int n = -1;
    always @(posedge clk) begin
        selfid <= 1'b0;
        if (ping_sent) n <= dly;
        else if (n > 0) n <= n - 1;
        else if (n == 0) begin
            selfid <= 1'b1;
            n <= -1;
        end
    end
endmodule

// ### verification/pxf_top_tb_top.sv
`timescale 1ns/1ps
module pxf_top_tb_top;
    logic CLK_SYS=0, RST_B=0, PSEL=0, PENABLE=0, PWRITE=0, PCFG_VALID=0, PCFG_R=0, PCFG_T=0, PORT_CONNECT=0;
    logic PORT_IS_CHILD=0, BUS_RESET_IN=0, BUS_IDLE=0, SYS_POWER_OFF=0, RX_ACTIVE=0, TX_PENDING=0, ACK_RX=0;
    logic CHILD_REPEAT_END=0, TX_PKT_START=0, TX_CONCAT=0, PING_RX=0, PING_TX_DONE=0, ASYNC_TX_DONE=0;
    logic PING_FLAG=0, PKT_RX=0, RCMD_VALID=0, RACC_VALID=0, RESUME_RX=0, SELFID_RX, e, rv, tv;
    logic [31:0] PWDATA=0, PRDATA, RXF_DATA, r;
    logic [7:0]  PADDR=0, RREPLY_DATA, phy=8'h3F, dly=8'h05;
    logic [5:0]  NODE_ID=0, PCFG_ROOT_NODE_FIELD=0, PCFG_GAP=0, rt, g;
    logic [3:0]  RCMD_PORT=0, RACC_ADDR=0;
    logic [2:0]  RCMD_CODE=0;
    logic [1:0]  TX_SPEED=0, SPD_CODE;
    logic [15:0] TSTAMP_VAL;
    logic PREADY, PSLVERR, RXF_PUSH, ARB_START, FLYBY_TX, BUS_RESET_OUT, SPD_SIG, SELFID_TX, TSTAMP_WR;
    logic ACK_TARDY, PME_B, DIS_NOTIFY_TX, RCONF_TX, RREPLY_TX, RESUME_TX, RESUME_START, PORT_BIAS_EN;
    int fail_count = 0, n_tests = 0, k, m[3] = '{6, 5, 3}; // never both modes off
    pxf_top u_pxf_top (.*);
    pxf_peer u_pxf_peer (.clk(CLK_SYS), .ping_sent(PING_TX_DONE), .dly(dly), .selfid(SELFID_RX));
    always #50 CLK_SYS = ~CLK_SYS;
    task cyc(input int n); repeat (n) @(posedge CLK_SYS); endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
        end
    endtask
    // Waits on the slave, never on a fixed latency
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d; cyc(1); PENABLE <= 1; k = 0;
        do begin cyc(1); k++; end while (PREADY !== 1'b1 && k < 20);
        if (k >= 20) fail_count++;
        r = PRDATA; e = PSLVERR; PSEL <= 0; PENABLE <= 0; cyc(1);
    endtask
    task end_sim;
        $display("tests %0d failures %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin #2000000; fail_count++; end_sim; end
    initial begin
        void'($urandom(46)); NODE_ID = 6'($urandom); cyc(4); RST_B <= 1; cyc(2);
        chk("pme", PME_B, 1); chk("bias", PORT_BIAS_EN, 1);
        apb(0, 8'h00, 0); chk("ctrl", r, 32'h07);
        apb(1, 8'h18, 32'hFFFFFFFF); chk("slverr", e, 1);
        apb(0, 8'h18, 0); chk("unmapped", r, 0);
        for (int i = 0; i < 3; i++) begin
            apb(1, 8'h00, m[i]); rt = $urandom_range(1) ? NODE_ID : 6'($urandom);
            rv = 1'($urandom); tv = 1'($urandom); g = 6'($urandom);
            {PCFG_ROOT_NODE_FIELD, PCFG_R, PCFG_T, PCFG_GAP} <= {rt, rv, tv, g}; PCFG_VALID <= 1; cyc(1);
            PCFG_VALID <= 0; cyc(1); chk("push", RXF_PUSH, m[i] == 6);
            if (m[i] == 6) chk("word", RXF_DATA, {2'h0, rt, rv, tv, g, 16'h0});
            // software mirrors packet in manual mode
            phy[7] = rv && rt == NODE_ID; if (tv) phy[5:0] = g;
            if (m[i] == 6) apb(1, 8'h04, {24'h0, phy});
            apb(0, 8'h04, 0); chk("phy1", r, phy);
        end
        RACC_ADDR <= 4'h1; RACC_VALID <= 1; cyc(1); RACC_VALID <= 0; cyc(2);
        chk("reply", RREPLY_DATA, phy);
        for (int c = 1; c < 6; c += 4) begin
            RCMD_CODE <= 3'(c); RCMD_VALID <= 1; cyc(1); RCMD_VALID <= 0; cyc(2);
            chk("notify", DIS_NOTIFY_TX, c == 1); cyc(2); chk("conf", RCONF_TX, 1);
            chk("bias", PORT_BIAS_EN, c == 5);
        end
        apb(1, 8'h00, 32'h97); chk("resume", {RESUME_TX, RESUME_START}, 2'b11);
        TX_CONCAT <= 1; TX_PKT_START <= 1; cyc(1); TX_SPEED <= 2; cyc(1);
        chk("spd0", {SPD_SIG, SPD_CODE}, 3'b100);
        TX_PKT_START <= 0; cyc(1); chk("spd1", {SPD_SIG, SPD_CODE}, 3'b110);
        PING_RX <= 1; cyc(1); PING_RX <= 0; cyc(1); chk("selfid", SELFID_TX, 1);
        PING_FLAG <= 1; dly <= 8'(5 + $urandom_range(20)); PING_TX_DONE <= 1; cyc(1); PING_TX_DONE <= 0; k = 0;
        while (TSTAMP_WR !== 1'b1 && k < 100) begin cyc(1); k++; end
        if (k >= 100) fail_count++;
        chk("stamp", TSTAMP_VAL + 16'h2 >= dly && TSTAMP_VAL <= dly + 3, 1);
        apb(1, 8'h00, 32'h13); // link off before power loss
        SYS_POWER_OFF <= 1; cyc(4); PKT_RX <= 1; cyc(1); PKT_RX <= 0; cyc(1);
        chk("tardy", ACK_TARDY, 1); cyc(1); chk("pme", PME_B, 0);
        end_sim;
    end
endmodule
